// file: bench/cic_mem_model.sv
// memory and stack model on the far side of the core's data bus
`default_nettype none

module cic_mem_model
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic             ack_o,
  output logic      [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem_q [logic [31:0]];
  logic [1:0]  wait_q;
  // ----------------------------
  // answer after 0..2 idle cycles
  // ----------------------------
  // read data toggles outside an ack so stale data never looks valid
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ack_o <= 1'b0;
      wait_q <= 2'h0;
      rdata_o <= 32'h5a5a_5a5a;
    end
    else if (req_i && !ack_o && wait_q == 2'h0)
    begin
      ack_o <= 1'b1;
      wait_q <= 2'($urandom_range(2));
      rdata_o <= we_i ? ~rdata_o : (mem_q.exists(addr_i) ? mem_q[addr_i] : 32'hdead_beef);
      if (we_i)
        mem_q[addr_i] = wdata_i;
    end
    else
    begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o)
        wait_q <= wait_q - 2'h1;
    end
  end
endmodule : cic_mem_model

`default_nettype wire

// file: bench/tb_cic_core.sv
// self-checking bench for the instruction class decoder and transfer engine
`default_nettype none

module tb_cic_core;
  import cic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, rst_n_i, vld, rdy, done, ill, req, we, ack;
  logic [6:0]  op;
  logic [1:0]  sz, md, ilen, msz;
  logic [3:0]  dst, src;
  logic [2:0]  cnt, vidx;
  logic [31:0] imm, addr, wdat, rdat, vdat;
  logic [31:0] v [4];
  cic_class_e  cls;
  logic [3:0]  exp_q [$];
  logic [3:0]  e;
  int          fail_count, comparisons, i, j;
  // ----------------------------
  // design, memory and clock
  // ----------------------------
  cic_core dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(vld),
    .instr_ready_o(rdy), .instr_op_i(op), .instr_size_i(sz), .instr_mode_i(md),
    .instr_dst_i(dst), .instr_src_i(src), .instr_imm_i(imm), .instr_imm_len_i(ilen),
    .instr_count_i(cnt), .done_o(done), .illegal_o(ill), .class_o(cls), .mem_req_o(req),
    .mem_we_o(we), .mem_addr_o(addr), .mem_wdata_o(wdat), .mem_size_o(msz),
    .mem_ack_i(ack), .mem_rdata_i(rdat), .view_idx_i(vidx), .view_data_o(vdat));
  cic_mem_model mem_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req), .we_i(we),
    .addr_i(addr), .wdata_i(wdat), .ack_o(ack), .rdata_o(rdat));
  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // ----------------------------
  // helpers
  // ----------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : check
  function automatic logic [3:0] mask_of(input int o);
    if (o >= 9 && o <= 12 || o == 23 || o >= 36 && o <= 49) return MASK_B;
    if (o == 15 || o == 16) return MASK_L;
    if (o >= 17 && o <= 20) return MASK_BW;
    if (o == 21 || o == 22) return MASK_WL;
    if (o >= 50 && o <= 64) return MASK_NONE;
    if (o >= 5 && o <= 35) return MASK_BWL;
    return 4'h0;
  endfunction : mask_of
  function automatic logic [2:0] class_of(input int o);
    return o < 5 ? 3'h0 : o < 24 ? 3'h1 : o < 28 ? 3'h2 : o < 36 ? 3'h3 :
           o < 50 ? 3'h4 : o < 55 ? 3'h5 : o < 64 ? 3'h6 : 3'h7;
  endfunction : class_of
  // ready comes back only after the last acked access has written its register
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clock_i);
    while (rdy !== 1'b1 && n < 300)
    begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 300)
    begin
      fail_count++;
      stop_test();
    end
  endtask : wait_ready
  // one-cycle valid, raised only once ready is seen, so it is always taken
  task automatic issue(input int o, input logic [1:0] s, input logic [1:0] m,
    input logic [3:0] d, input logic [31:0] im, input logic [1:0] il,
    input logic [2:0] c, input logic bad);
    wait_ready();
    @(posedge clock_i);
    {op, sz, md, dst, src, imm, ilen, cnt} <= {7'(o), s, m, d, d, im, il, c};
    vld <= 1'b1;
    exp_q.push_back({bad, class_of(o)});
    @(posedge clock_i);
    vld <= 1'b0;
  endtask : issue
  task automatic view(input logic [2:0] r, input logic [31:0] ex);
    wait_ready();
    @(posedge clock_i);
    vidx <= r;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    check("view", ex, vdat);
  endtask : view
  always @(negedge clock_i)
  begin
    if (req === 1'b1 && msz !== SZ_B)
      check("addr_bit0", 32'h0, 32'(addr[0]));
    if (done === 1'b1 || ill === 1'b1)
    begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 4'hf;
      check("illegal", 32'(e[3]), 32'(ill));
      if (e[3] == 1'b0)
        check("class", 32'(e[2:0]), 32'(cls));
    end
  end
  // ----------------------------
  // scenarios
  // ----------------------------
  initial
  begin
    {vld, op, sz, md, dst, src, imm, ilen, cnt, vidx} = '0;
    rst_n_i = 1'b0;
    fail_count = 0;
    comparisons = 0;
    void'($urandom(32'h6120));
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      issue(OP_MOV, SZ_L, MODE_IMM, 4'h5, 32'hf1e2_d3c4, 2'(i), 3'h0, 1'b0);
      view(3'h5, 32'hf1e2_d3c4 & 32'(64'h1_0000_0000 >> (24 - 8 * i)) - 32'h1);
    end
    for (i = 1; i < 4; i++)
    begin
      v[i] = $urandom();
      issue(OP_MOV, SZ_L, MODE_IMM, 4'(i), v[i], 2'h3, 3'h0, 1'b0);
    end
    issue(OP_MOV, SZ_L, MODE_IMM, 4'h7, 32'h101, 2'h3, 3'h0, 1'b0);
    issue(OP_PUSH, SZ_L, MODE_REG, 4'h1, 32'h0, 2'h0, 3'h0, 1'b0);
    issue(OP_POP, SZ_L, MODE_REG, 4'h4, 32'h0, 2'h0, 3'h0, 1'b0);
    view(3'h4, v[1]);
    view(3'h7, 32'h101);
    issue(OP_MOV, SZ_L, MODE_IMM, 4'h6, 32'h40, 2'h3, 3'h0, 1'b0);
    issue(OP_MOV, SZ_L, MODE_STORE, 4'h6, 32'h0, 2'h0, 3'h0, 1'b0);
    issue(OP_MOV, SZ_L, MODE_IMM, 4'h6, 32'h41, 2'h3, 3'h0, 1'b0);
    issue(OP_MOV, SZ_L, MODE_LOAD, 4'h6, 32'h0, 2'h0, 3'h0, 1'b0);
    view(3'h6, 32'h40);
    issue(OP_STORE_MULTIPLE, SZ_L, MODE_REG, 4'h1, 32'h0, 2'h0, 3'h3, 1'b0);
    for (i = 1; i < 4; i++)
      issue(OP_MOV, SZ_L, MODE_IMM, 4'(i), 32'h0, 2'h3, 3'h0, 1'b0);
    issue(OP_LOAD_MULTIPLE, SZ_L, MODE_REG, 4'h1, 32'h0, 2'h0, 3'h3, 1'b0);
    for (i = 1; i < 4; i++)
      view(3'(i), v[i]);
    issue(OP_LOAD_MULTIPLE, SZ_L, MODE_REG, 4'h1, 32'h0, 2'h0, 3'h1, 1'b1);
    issue(OP_STORE_MULTIPLE, SZ_W, MODE_REG, 4'h1, 32'h0, 2'h0, 3'h2, 1'b1);
    issue(OP_PUSH, SZ_B, MODE_REG, 4'h1, 32'h0, 2'h0, 3'h0, 1'b1);
    for (i = 5; i < 67; i++)
      for (j = 0; j < 4; j++)
        issue(i, 2'(j), MODE_REG, 4'h0, 32'h0, 2'h0, 3'h0,
              ((mask_of(i) >> j) & 4'h1) == 4'h0);
    for (i = 0; i < 300 && exp_q.size() > 0; i++)
      @(posedge clock_i);
    if (exp_q.size() > 0)
      fail_count++;
    stop_test();
  end
endmodule : tb_cic_core

`default_nettype wire

// file: rtl/cic_core.sv
// instruction class decoder with data transfer engine
`default_nettype none

module cic_core
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        instr_valid_i,
  output logic             instr_ready_o,
  input  wire logic [6:0]  instr_op_i,
  input  wire logic [1:0]  instr_size_i,
  input  wire logic [1:0]  instr_mode_i,
  input  wire logic [3:0]  instr_dst_i,
  input  wire logic [3:0]  instr_src_i,
  input  wire logic [31:0] instr_imm_i,
  input  wire logic [1:0]  instr_imm_len_i,
  input  wire logic [2:0]  instr_count_i,
  output logic             done_o,
  output logic             illegal_o,
  output cic_pkg::cic_class_e class_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [31:0] mem_addr_o,
  output logic      [31:0] mem_wdata_o,
  output logic      [1:0]  mem_size_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  input  wire logic [2:0]  view_idx_i,
  output logic      [31:0] view_data_o
);
  import cic_pkg::*;

  // ------------------------------------------------------------------
  // decode functions
  // ------------------------------------------------------------------
  function automatic cic_class_e class_of(input logic [6:0] op);
    cic_class_e c;
    if (op < OP_ARITH_FIRST)        c = CL_TRANSFER;
    else if (op < OP_LOGIC_FIRST)   c = CL_ARITH;
    else if (op < OP_SHIFT_FIRST)   c = CL_LOGIC;
    else if (op < OP_BIT_FIRST)     c = CL_SHIFT;
    else if (op < OP_BRANCH_FIRST)  c = CL_BIT;
    else if (op < OP_SYSTEM_FIRST)  c = CL_BRANCH;
    else if (op < OP_BLOCK_MOVE)    c = CL_SYSTEM;
    else                            c = CL_BLOCK;
    return c;
  endfunction : class_of

  // peripheral moves and codes past the table get an empty mask
  function automatic logic [3:0] size_mask(input logic [6:0] op);
    logic [3:0] m;
    m = MASK_BWL;
    if (op >= OP_COUNT)                   m = 4'h0;          // [RQ1]
    else if (op == OP_POP || op == OP_PUSH) m = MASK_WL;     // [RQ3] [RQ4]
    else if (op == OP_LOAD_MULTIPLE || op == OP_STORE_MULTIPLE)
      m = MASK_L;                                            // [RQ5] [RQ6]
    else if (op >= OP_ADD_WITH_CARRY && op <= OP_DEC_ADJUST_SUB)
      m = MASK_B;                                            // [RQ10]
    else if (op == OP_ADD_SMALL || op == OP_SUB_SMALL)       m = MASK_L;
    else if (op >= OP_MULDIV_FIRST && op <= OP_MULDIV_LAST)  m = MASK_BW; // [RQ11]
    else if (op >= OP_EXT_FIRST && op <= OP_EXT_LAST)        m = MASK_WL;
    else if (op == OP_TEST_AND_SET)                          m = MASK_B;
    else if (op >= OP_BIT_FIRST && op < OP_BRANCH_FIRST)     m = MASK_B;  // [RQ13]
    else if (op >= OP_BRANCH_FIRST)                          m = MASK_NONE; // [RQ14] [RQ15]
    return m;
  endfunction : size_mask

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  cic_state_e  state_q;
  logic [6:0]  op_q;
  logic [1:0]  size_q;
  logic [3:0]  dst_q;
  logic [2:0]  idx_q;
  logic [2:0]  left_q;

  logic [31:0] rd_data_w;
  logic [31:0] ptr_w;
  logic [31:0] sp_w;
  logic [31:0] view_w;

  // ------------------------------------------------------------------
  // decode of the offered instruction
  // ------------------------------------------------------------------
  wire logic [3:0]  mask_w    = size_mask(instr_op_i);
  wire logic        is_pop_w  = instr_op_i == OP_POP;
  wire logic        is_push_w = instr_op_i == OP_PUSH;
  wire logic        is_ldm_w  = instr_op_i == OP_LOAD_MULTIPLE;
  wire logic        is_stm_w  = instr_op_i == OP_STORE_MULTIPLE;
  wire logic        is_mov_w  = instr_op_i == OP_MOV;
  wire logic        multi_w   = is_ldm_w || is_stm_w;
  wire logic [3:0]  last_w    = {1'b0, instr_dst_i[2:0]} + {1'b0, instr_count_i} - 4'h1;
  // a list reaching register seven is refused rather than trusted
  wire logic        list_ok_w = instr_count_i >= MULTI_MIN && last_w <= MULTI_LAST; // [RQ7]
  wire logic        legal_w   = mask_w[instr_size_i] && (!multi_w || list_ok_w); // [RQ1] [RQ12]
  wire logic        mov_ld_w  = is_mov_w && instr_mode_i == MODE_LOAD;
  wire logic        mov_st_w  = is_mov_w && instr_mode_i == MODE_STORE;
  wire logic        to_mem_w  = legal_w && (is_pop_w || is_push_w || multi_w
                                            || mov_ld_w || mov_st_w);
  wire logic        accept_w  = instr_valid_i && state_q == ST_IDLE;
  wire logic        start_w   = accept_w && to_mem_w;
  wire logic        ack_w     = state_q == ST_MEM && mem_ack_i;
  wire logic        more_w    = ack_w && left_q != 3'h1;
  wire logic        q_ldm_w   = op_q == OP_LOAD_MULTIPLE;
  wire logic        q_stm_w   = op_q == OP_STORE_MULTIPLE;
  wire logic        q_load_w  = q_ldm_w || op_q == OP_POP || (op_q == OP_MOV && !mem_we_o);
  wire logic [31:0] step_w    = instr_size_i == SZ_L ? STEP_LONG : STEP_WORD;
  wire logic [31:0] step_q_w  = size_q == SZ_L ? STEP_LONG : STEP_WORD;

  // ------------------------------------------------------------------
  // immediate length and register moves
  // ------------------------------------------------------------------
  wire logic [31:0] imm_w = instr_imm_len_i == IMM_8  ? {24'h0, instr_imm_i[7:0]}  :
                            instr_imm_len_i == IMM_16 ? {16'h0, instr_imm_i[15:0]} :
                            instr_imm_len_i == IMM_24 ? {8'h0, instr_imm_i[23:0]}  :
                            instr_imm_i;                                        // [RQ17]
  wire logic mov_reg_w = accept_w && legal_w && is_mov_w
                         && (instr_mode_i == MODE_REG || instr_mode_i == MODE_IMM);

  // ------------------------------------------------------------------
  // access address: push forms pre-decrement, pop forms use sp as is
  // ------------------------------------------------------------------
  wire logic [31:0] first_addr_w =
      (is_push_w || is_stm_w) ? sp_w - step_w :                         // [RQ4] [RQ6]
      (is_pop_w || is_ldm_w)  ? sp_w :                                  // [RQ3] [RQ5]
      ptr_w;                                                            // [RQ2]
  wire logic [31:0] next_addr_w = q_ldm_w ? sp_w + STEP_LONG : sp_w - STEP_LONG; // [RQ5] [RQ6]
  wire logic [31:0] raw_addr_w  = more_w ? next_addr_w : first_addr_w;
  wire logic [1:0]  iss_size_w  = more_w ? SZ_L : instr_size_i;
  // odd word/long addresses silently fall back to the even byte
  wire logic [31:0] iss_addr_w  = {raw_addr_w[31:1],
                                   raw_addr_w[0] && iss_size_w == SZ_B};        // [RQ18]
  wire logic        iss_we_w    = more_w ? q_stm_w : (is_push_w || is_stm_w || mov_st_w);

  // ------------------------------------------------------------------
  // register file hookup
  // ------------------------------------------------------------------
  wire logic [3:0] rd_code_w = more_w   ? {1'b0, idx_q + 3'h1} :
                               is_stm_w ? {1'b0, instr_dst_i[2:0]} : instr_src_i;
  wire logic [2:0] ptr_idx_w = mov_st_w ? instr_dst_i[2:0] : instr_src_i[2:0];
  wire logic       ld_wr_w   = ack_w && q_load_w;
  wire logic       wr_en_w   = mov_reg_w || ld_wr_w;
  wire logic [3:0] wr_code_w = !ld_wr_w ? instr_dst_i : q_ldm_w ? {1'b0, idx_q} : dst_q;
  wire logic [1:0] wr_size_w = ld_wr_w ? size_q : instr_size_i;
  wire logic [31:0] wr_data_w = ld_wr_w ? mem_rdata_i :
                                instr_mode_i == MODE_IMM ? imm_w : rd_data_w;   // [RQ2]
  wire logic pop_sp_w  = ack_w && (op_q == OP_POP || q_ldm_w);          // [RQ3] [RQ5]
  wire logic push_sp_w = (start_w && (is_push_w || is_stm_w)) || (more_w && q_stm_w);
  wire logic sp_wr_w   = pop_sp_w || push_sp_w;
  wire logic [31:0] sp_data_w = pop_sp_w ? sp_w + step_q_w : raw_addr_w;   // [RQ4] [RQ6]

  cic_regfile u_regfile (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .wr_en_i    (wr_en_w),
    .wr_code_i  (wr_code_w),
    .wr_size_i  (wr_size_w),
    .wr_data_i  (wr_data_w),
    .sp_wr_en_i (sp_wr_w),
    .sp_data_i  (sp_data_w),
    .rd_code_i  (rd_code_w),
    .rd_size_i  (iss_size_w),
    .rd_data_o  (rd_data_w),
    .ptr_idx_i  (ptr_idx_w),
    .ptr_o      (ptr_w),
    .sp_o       (sp_w),
    .view_idx_i (view_idx_i),
    .view_o     (view_w)
  );

  assign instr_ready_o = state_q == ST_IDLE;

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_IDLE;
      op_q    <= OP_MOV;
      size_q  <= SZ_B;
      dst_q   <= 4'h0;
      idx_q   <= 3'h0;
      left_q  <= 3'h0;
    end
    else if (start_w)
    begin
      state_q <= ST_MEM;
      op_q    <= instr_op_i;
      size_q  <= instr_size_i;
      dst_q   <= instr_dst_i;
      // load_multiple fills from the top of the list down
      idx_q   <= is_ldm_w ? last_w[2:0] : instr_dst_i[2:0];
      left_q  <= multi_w ? instr_count_i : 3'h1;
    end
    else if (more_w)
    begin
      idx_q  <= q_ldm_w ? idx_q - 3'h1 : idx_q + 3'h1;
      left_q <= left_q - 3'h1;
    end
    else if (ack_w)
      state_q <= ST_IDLE;
  end

  // ------------------------------------------------------------------
  // bus and result outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= RESET_VALUE;
      mem_wdata_o <= RESET_VALUE;
      mem_size_o  <= SZ_B;
    end
    else if (start_w || more_w)
    begin
      mem_req_o   <= 1'b1;
      mem_we_o    <= iss_we_w;
      mem_addr_o  <= iss_addr_w;
      mem_wdata_o <= rd_data_w;
      mem_size_o  <= iss_size_w;
    end
    else if (ack_w)
      mem_req_o <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      done_o      <= 1'b0;
      illegal_o   <= 1'b0;
      class_o     <= CL_TRANSFER;
      view_data_o <= RESET_VALUE;
    end
    else
    begin
      done_o      <= (accept_w && legal_w && !to_mem_w) || (ack_w && !more_w);
      illegal_o   <= accept_w && !legal_w;                                  // [RQ1]
      view_data_o <= view_w;
      if (accept_w)
        class_o <= class_of(instr_op_i);                                    // [RQ1] [RQ14]
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_accept(logic [6:0] op);
    accept_w && instr_op_i == op && legal_w;
  endsequence

  property p_bad_code;
    @(posedge clock_i) disable iff (!rst_n_i)
      accept_w && instr_op_i >= OP_COUNT |=> illegal_o && !done_o;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("unknown code not refused"); // [RQ1]

  property p_push_first;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_accept(OP_PUSH) |=> mem_req_o && mem_we_o && sp_w == $past(sp_w) - $past(step_w)
                            && mem_addr_o[31:1] == sp_w[31:1];
  endproperty
  a_push_first: assert property (p_push_first) else $error("push did not predecrement"); // [RQ4]

  property p_pop_inc;
    @(posedge clock_i) disable iff (!rst_n_i)
      ack_w && op_q == OP_POP |=> sp_w == $past(sp_w) + $past(step_q_w) && done_o;
  endproperty
  a_pop_inc: assert property (p_pop_inc) else $error("pop did not postincrement"); // [RQ3]

  property p_multi_long;
    @(posedge clock_i) disable iff (!rst_n_i)
      mem_req_o && (q_ldm_w || q_stm_w) |-> mem_size_o == SZ_L;
  endproperty
  a_multi_long: assert property (p_multi_long) else $error("multiple not longword"); // [RQ5]

  property p_stm_walk;
    @(posedge clock_i) disable iff (!rst_n_i)
      more_w && q_stm_w |=> sp_w == $past(sp_w) - STEP_LONG && mem_addr_o[31:1] == sp_w[31:1];
  endproperty
  a_stm_walk: assert property (p_stm_walk) else $error("store_multiple step wrong"); // [RQ6]

  property p_byte_only;
    @(posedge clock_i) disable iff (!rst_n_i)
      accept_w && instr_size_i != SZ_B && instr_op_i >= OP_ADD_WITH_CARRY
      && instr_op_i <= OP_DEC_ADJUST_SUB |=> illegal_o;
  endproperty
  a_byte_only: assert property (p_byte_only) else $error("byte-only op took wide size"); // [RQ10]

  property p_muldiv;
    @(posedge clock_i) disable iff (!rst_n_i)
      accept_w && instr_op_i >= OP_MULDIV_FIRST && instr_op_i <= OP_MULDIV_LAST
      |=> illegal_o == ($past(instr_size_i) == SZ_L || $past(instr_size_i) == SZ_N);
  endproperty
  a_muldiv: assert property (p_muldiv) else $error("multiply/divide size check wrong"); // [RQ11]

  property p_bit_byte;
    @(posedge clock_i) disable iff (!rst_n_i)
      accept_w && instr_op_i >= OP_BIT_FIRST && instr_op_i < OP_BRANCH_FIRST
      |=> illegal_o == ($past(instr_size_i) != SZ_B) && class_o == CL_BIT;
  endproperty
  a_bit_byte: assert property (p_bit_byte) else $error("bit op class or size wrong"); // [RQ13]

  property p_align;
    @(posedge clock_i) disable iff (!rst_n_i)
      mem_req_o && mem_size_o != SZ_B |-> !mem_addr_o[0];
  endproperty
  a_align: assert property (p_align) else $error("wide access at odd address"); // [RQ18]

  property p_imm8;
    @(posedge clock_i) disable iff (!rst_n_i)
      mov_reg_w && instr_mode_i == MODE_IMM && instr_imm_len_i == IMM_8
      |-> wr_data_w[31:8] == 24'h0;
  endproperty
  a_imm8: assert property (p_imm8) else $error("8-bit immediate not trimmed"); // [RQ17]

endmodule : cic_core

`default_nettype wire

// file: rtl/cic_pkg.sv
// constants and types for the instruction class decoder and transfer engine
//
// Summary of operation
// RQ1: decoder knows sixty-five instructions in eight function classes
// RQ2: move copies byte, word or long between registers, memory, or loads immediate
// RQ3: pop reads at stack pointer then post-increments it; word or long only
// RQ4: push pre-decrements stack pointer then writes register; word or long only
// RQ5: load_multiple pops two or more consecutive registers as longwords, post-incrementing
// RQ6: store_multiple pushes two or more registers as longwords, pre-decrementing
// RQ7: software keeps register seven out of multiple-register lists
// RQ8: software never uses the byte peripheral move instructions
// RQ9: software uses only registers 0, 1, 4, 5 as test_and_set pointer
// RQ10: add_with_carry, subtract_with_borrow, decimal adjusts accepted in byte size only
// RQ11: multiply and divide, signed and unsigned, accepted in byte and word only
// RQ12: eight shift and rotate operations, each valid in byte, word, long
// RQ13: fourteen bit operations, byte operands only
// RQ14: branch class holds five types, conditional branch family among them
// RQ15: system control class holds nine instructions
// RQ16: registers addressable as 8-bit halves, 16-bit halves and 32-bit words
// RQ17: immediate fields come in 8, 16, 24 or 32 bit lengths
// RQ18: word and long accesses force address bit zero low, no error
// RQ19: software uses word or long size for stack accesses via register seven
`default_nettype none

package cic_pkg;

  // ------------------------------------------------------------------
  // operand sizes and size legality masks {none, long, word, byte}
  // ------------------------------------------------------------------
  localparam logic [1:0] SZ_B      = 2'h0;
  localparam logic [1:0] SZ_W      = 2'h1;
  localparam logic [1:0] SZ_L      = 2'h2;
  localparam logic [1:0] SZ_N      = 2'h3;
  localparam logic [3:0] MASK_BWL  = 4'h7;
  localparam logic [3:0] MASK_BW   = 4'h3;
  localparam logic [3:0] MASK_WL   = 4'h6;
  localparam logic [3:0] MASK_B    = 4'h1;
  localparam logic [3:0] MASK_L    = 4'h4;
  localparam logic [3:0] MASK_NONE = 4'h8;

  // ------------------------------------------------------------------
  // instruction indices, grouped by class
  // ------------------------------------------------------------------
  localparam logic [6:0] OP_MOV              = 7'h00;
  localparam logic [6:0] OP_POP              = 7'h01;
  localparam logic [6:0] OP_PUSH             = 7'h02;
  localparam logic [6:0] OP_LOAD_MULTIPLE    = 7'h03;
  localparam logic [6:0] OP_STORE_MULTIPLE   = 7'h04;
  localparam logic [6:0] OP_ARITH_FIRST      = 7'h05;
  localparam logic [6:0] OP_ADD_WITH_CARRY   = 7'h09;
  localparam logic [6:0] OP_DEC_ADJUST_SUB   = 7'h0c;
  localparam logic [6:0] OP_ADD_SMALL        = 7'h0f;
  localparam logic [6:0] OP_SUB_SMALL        = 7'h10;
  localparam logic [6:0] OP_MULDIV_FIRST     = 7'h11;
  localparam logic [6:0] OP_MULDIV_LAST      = 7'h14;
  localparam logic [6:0] OP_EXT_FIRST        = 7'h15;
  localparam logic [6:0] OP_EXT_LAST         = 7'h16;
  localparam logic [6:0] OP_TEST_AND_SET     = 7'h17;
  localparam logic [6:0] OP_LOGIC_FIRST      = 7'h18;
  localparam logic [6:0] OP_SHIFT_FIRST      = 7'h1c;
  localparam logic [6:0] OP_BIT_FIRST        = 7'h24;
  localparam logic [6:0] OP_BRANCH_FIRST     = 7'h32;
  localparam logic [6:0] OP_SYSTEM_FIRST     = 7'h37;
  localparam logic [6:0] OP_BLOCK_MOVE       = 7'h40;
  localparam logic [6:0] OP_COUNT            = 7'h41;
  localparam logic [6:0] OP_MOVE_FROM_PERIPH = 7'h41;
  localparam logic [6:0] OP_MOVE_TO_PERIPH   = 7'h42;

  // ------------------------------------------------------------------
  // move operand forms, immediate lengths, stack
  // ------------------------------------------------------------------
  localparam logic [1:0]  MODE_REG    = 2'h0;
  localparam logic [1:0]  MODE_IMM    = 2'h1;
  localparam logic [1:0]  MODE_LOAD   = 2'h2;
  localparam logic [1:0]  MODE_STORE  = 2'h3;
  localparam logic [1:0]  IMM_8       = 2'h0;
  localparam logic [1:0]  IMM_16      = 2'h1;
  localparam logic [1:0]  IMM_24      = 2'h2;
  localparam logic [2:0]  SP_INDEX    = 3'h7;
  localparam logic [2:0]  MULTI_MIN   = 3'h2;
  localparam logic [3:0]  MULTI_LAST  = 4'h6;
  localparam logic [31:0] STEP_WORD   = 32'h2;
  localparam logic [31:0] STEP_LONG   = 32'h4;
  localparam logic [31:0] RESET_VALUE = 32'h0;

  typedef enum logic [2:0] {
    CL_TRANSFER = 3'b000,
    CL_ARITH    = 3'b001,
    CL_LOGIC    = 3'b010,
    CL_SHIFT    = 3'b011,
    CL_BIT      = 3'b100,
    CL_BRANCH   = 3'b101,
    CL_SYSTEM   = 3'b110,
    CL_BLOCK    = 3'b111
  } cic_class_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM  = 2'b01
  } cic_state_e;

endpackage : cic_pkg

`default_nettype wire

// file: rtl/cic_regfile.sv
// general register file with byte, word and long views
`default_nettype none

module cic_regfile
  import cic_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        wr_en_i,
  input  wire logic [3:0]  wr_code_i,
  input  wire logic [1:0]  wr_size_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        sp_wr_en_i,
  input  wire logic [31:0] sp_data_i,
  input  wire logic [3:0]  rd_code_i,
  input  wire logic [1:0]  rd_size_i,
  output logic      [31:0] rd_data_o,
  input  wire logic [2:0]  ptr_idx_i,
  output logic      [31:0] ptr_o,
  output logic      [31:0] sp_o,
  input  wire logic [2:0]  view_idx_i,
  output logic      [31:0] view_o
);

  logic [31:0] regs_q [8];

  // code[3] picks low byte / extended half; code[2:0] picks the register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [3:0] code,
                                        input logic [1:0] size, input logic [31:0] data);
    logic [31:0] r;
    r = old;
    unique case (size)
      SZ_B:    if (code[3]) r[7:0] = data[7:0]; else r[15:8] = data[7:0];
      SZ_W:    if (code[3]) r[31:16] = data[15:0]; else r[15:0] = data[15:0];
      default: r = data;
    endcase
    return r;
  endfunction : merge

  function automatic logic [31:0] extract(input logic [31:0] v, input logic [3:0] code,
                                          input logic [1:0] size);
    logic [31:0] r;
    r = v;
    unique case (size)
      SZ_B:    r = {24'h0, code[3] ? v[7:0] : v[15:8]};
      SZ_W:    r = {16'h0, code[3] ? v[31:16] : v[15:0]};
      default: r = v;
    endcase
    return r;
  endfunction : extract

  // a data write to register seven outranks the stack pointer update
  for (genvar g = 0; g < 8; g++) begin : g_reg
    always_ff @(posedge clock_i)
    begin
      if (!rst_n_i)
        regs_q[g] <= RESET_VALUE;
      else if (wr_en_i && wr_code_i[2:0] == 3'(g))
        regs_q[g] <= merge(regs_q[g], wr_code_i, wr_size_i, wr_data_i); // [RQ16]
      else if (sp_wr_en_i && SP_INDEX == 3'(g))
        regs_q[g] <= sp_data_i;
    end
  end

  assign rd_data_o = extract(regs_q[rd_code_i[2:0]], rd_code_i, rd_size_i); // [RQ16]
  assign ptr_o     = regs_q[ptr_idx_i];
  assign sp_o      = regs_q[SP_INDEX];
  assign view_o    = regs_q[view_idx_i];

endmodule : cic_regfile

`default_nettype wire
